// *** inc/msel_params.svh ***
// Bit positions, masks and reset values of the module status and event registers
`ifndef MSEL_PARAMS_SVH
`define MSEL_PARAMS_SVH

// Live status bit positions
`define MSEL_ST_RAMP_LIM 21
`define MSEL_ST_FAST_DOWN 16
`define MSEL_ST_KILL 15
`define MSEL_ST_TEMP_OK 14
`define MSEL_ST_SUPPLY_OK 13
`define MSEL_ST_MOD_OK 12
`define MSEL_ST_EV_ACTIVE 11
`define MSEL_ST_LOOP_OK 10
`define MSEL_ST_NO_RAMP 9
`define MSEL_ST_NO_SUM_ERR 8
`define MSEL_ST_INPUT_ERR 6
`define MSEL_ST_SERVICE 4
`define MSEL_ST_HV_ON 3
`define MSEL_ST_FINE_ADJ 0
`define MSEL_ST_VALID 32'h0021ff59
`define MSEL_ST_RESET 32'h00000000

// Event bit positions
`define MSEL_EV_TEMP 14
`define MSEL_EV_SUPPLY 13
`define MSEL_EV_LOOP 10
`define MSEL_EV_INPUT 6
`define MSEL_EV_SERVICE 4
`define MSEL_EV_VALID 32'h00006450
`define MSEL_EV_BLOCKING 32'h00006410
`define MSEL_EV_RESET 32'h00000000

// Synchronised pin vector layout
`define MSEL_PIN_TEMP_BAD 0
`define MSEL_PIN_SUPPLY_BAD 1
`define MSEL_PIN_LOOP_OPEN 2
`define MSEL_PIN_HW_FAIL 3
`define MSEL_PIN_PWR_FAIL 4
`define MSEL_PIN_COUNT 5

`endif

// *** inc/msel_pkg.sv ***
// Types shared by the module status and event logic
package msel_pkg;

	// Decoded host commands
	typedef enum logic [3:0] {
		MSEL_OP_NOP,
		MSEL_OP_READ_STATUS,
		MSEL_OP_READ_EVENT,
		MSEL_OP_EVENT_W1C,
		MSEL_OP_CLEAR_ALL,
		MSEL_OP_CLEAR_CH,
		MSEL_OP_SET_VALUE,
		MSEL_OP_HV_ON,
		MSEL_OP_HV_OFF
	} msel_op_t;

	// High-voltage permission state
	typedef enum logic [1:0] {
		MSEL_HV_OFF,
		MSEL_HV_ON,
		MSEL_HV_DEAD
	} msel_hv_t;

	// Whole state of the core
	typedef struct packed {
		logic [31:0] sts;
		logic [31:0] evt;
		msel_hv_t hv;
		logic hv_en;
		logic in_err;
		logic rsp_valid;
		logic [31:0] rsp_data;
		logic rsp_refused;
		logic clr_ch;
		logic set_grant;
		logic on_grant;
		logic ramp_off;
		logic emcy_off;
		logic fast_down;
	} msel_state_t;

endpackage

// *** verilog/msel_sync.sv ***
// Two-stage synchroniser for asynchronous module condition pins
`timescale 1ns/10ps
module msel_sync
	import msel_pkg::*;
#(
	parameter int W = 5
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} msel_sync_t;

	msel_sync_t st_q;
	msel_sync_t st_d;

	// First stage feeds only the second; nothing else may look at it
	always_comb begin
		st_d = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
	end

	// Reset to zero means "no fault seen" on every pin
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.s2;

endmodule

// *** verilog/msel_core.sv ***
// Module live status, sticky events and high-voltage blocking
`timescale 1ns/10ps
`include "msel_params.svh"

// Behaviour
// RULE1: Event bit sets while its condition holds
// RULE2: Events sticky; cleared by writing one
// RULE3: Global clear wipes module and channel events
// RULE4: Channel clear command resets channel events
// RULE5: Blocking refuses voltage increase while on
// RULE6: Blocking refuses switching high voltage on
// RULE7: Clearing event or mask releases blocking
// RULE8: Temperature 14, supply 13, loop 10 block
// RULE9: Input error 6 free, service 4 blocks
// RULE10: Only blocking events inhibit voltage changes
// RULE11: Module good is sum-ok without bad events
// RULE12: Sum-ok when no channel shows faults
// RULE13: Event active is masked channel summary OR
// RULE14: HV-on when any channel generates or exceeds
// RULE15: Input error sets on range, clears on success
// RULE16: Temperature bad ramps all channels off
// RULE17: Safety loop open shuts down immediately
// RULE18: Hardware failure flags service, locks HV off
// RULE19: No-ramp when all stable, none ramping
// RULE20: Power fail reports fast ramp down
// RULE21: Ramp-limited under kill or deferred trip
// RULE22: Fine-adjust and kill status mirror modes
// RULE23: Live status tracks condition without latching
// RULE24: Reserved bits read zero, ignore writes
module msel_core
	import msel_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic temp_good,
	input wire logic supply_good,
	input wire logic safety_loop_closed,
	input wire logic hw_fail,
	input wire logic power_fail,
	input wire logic [31:0] ch_volt_limit,
	input wire logic [31:0] ch_curr_limit,
	input wire logic [31:0] ch_curr_trip,
	input wire logic [31:0] ch_ext_inhibit,
	input wire logic [31:0] ch_volt_bounds,
	input wire logic [31:0] ch_curr_bounds,
	input wire logic [31:0] ch_arc_error,
	input wire logic [31:0] ch_event_summary,
	input wire logic [31:0] ch_event_chmask,
	input wire logic [31:0] ch_hv_active,
	input wire logic [31:0] ch_above_thresh,
	input wire logic [31:0] ch_stable,
	input wire logic [31:0] ch_ramping,
	input wire logic [31:0] event_mask,
	input wire logic fine_adjust_en,
	input wire logic kill_en,
	input wire logic delayed_trip_act,
	input wire logic ramp_limit_dis,
	input wire logic cmd_valid,
	input wire msel_op_t cmd_op,
	input wire logic [31:0] cmd_data,
	input wire logic cmd_range_ok,
	input wire logic cmd_raise,
	output logic rsp_valid,
	output logic [31:0] rsp_data,
	output logic rsp_refused,
	output logic [31:0] module_live_status,
	output logic [31:0] module_event_latch,
	output logic clear_channel_events_cmd,
	output logic set_value_grant,
	output logic hv_on_grant,
	output logic hv_enable,
	output logic ramp_down_all,
	output logic emergency_off_all,
	output logic power_fail_discharge,
	output logic hardware_fault_flag,
	output logic module_healthy,
	output logic all_channels_healthy
);

	msel_state_t st_q;
	msel_state_t st_d;
	logic [`MSEL_PIN_COUNT-1:0] pin_raw;
	logic [`MSEL_PIN_COUNT-1:0] pin_s;
	logic temp_bad_s;
	logic supply_bad_s;
	logic loop_open_s;
	logic hw_fail_s;
	logic pwr_fail_s;
	logic [31:0] sum_err;
	logic [31:0] live;
	logic [31:0] ev_set;
	logic [31:0] ev_clr;
	logic blocking;
	logic hv_live;

	// The three good-polarity pins are inverted to "bad" polarity so that a zero reset means healthy
	assign pin_raw[`MSEL_PIN_TEMP_BAD] = ~temp_good;
	assign pin_raw[`MSEL_PIN_SUPPLY_BAD] = ~supply_good;
	assign pin_raw[`MSEL_PIN_LOOP_OPEN] = ~safety_loop_closed;
	assign pin_raw[`MSEL_PIN_HW_FAIL] = hw_fail;
	assign pin_raw[`MSEL_PIN_PWR_FAIL] = power_fail;

	msel_sync #(
		.W(`MSEL_PIN_COUNT)
	) u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.din(pin_raw),
		.dout(pin_s)
	);

	assign temp_bad_s = pin_s[`MSEL_PIN_TEMP_BAD];
	assign supply_bad_s = pin_s[`MSEL_PIN_SUPPLY_BAD];
	assign loop_open_s = pin_s[`MSEL_PIN_LOOP_OPEN];
	assign hw_fail_s = pin_s[`MSEL_PIN_HW_FAIL];
	assign pwr_fail_s = pin_s[`MSEL_PIN_PWR_FAIL];

	// Per-channel fault summary feeding the sum-ok flag
	assign sum_err = ch_volt_limit | ch_curr_limit | ch_curr_trip | ch_ext_inhibit
		| ch_volt_bounds | ch_curr_bounds | ch_arc_error; // RULE12
	assign hv_live = |(ch_hv_active | ch_above_thresh); // RULE14

	// Live status is rebuilt every cycle, never latched
	always_comb begin
		live = '0;
		live[`MSEL_ST_RAMP_LIM] = (kill_en | delayed_trip_act) & ~ramp_limit_dis; // RULE21
		live[`MSEL_ST_FAST_DOWN] = pwr_fail_s; // RULE20
		live[`MSEL_ST_KILL] = kill_en; // RULE22
		live[`MSEL_ST_TEMP_OK] = ~temp_bad_s;
		live[`MSEL_ST_SUPPLY_OK] = ~supply_bad_s;
		live[`MSEL_ST_MOD_OK] = ~|sum_err & ~(st_q.evt[`MSEL_EV_TEMP]
			| st_q.evt[`MSEL_EV_SUPPLY] | st_q.evt[`MSEL_EV_LOOP]); // RULE11
		live[`MSEL_ST_EV_ACTIVE] = |(ch_event_summary & ch_event_chmask); // RULE13
		live[`MSEL_ST_LOOP_OK] = ~loop_open_s;
		live[`MSEL_ST_NO_RAMP] = (&ch_stable) & ~|ch_ramping; // RULE19
		live[`MSEL_ST_NO_SUM_ERR] = ~|sum_err; // RULE12
		live[`MSEL_ST_INPUT_ERR] = st_q.in_err; // RULE15
		live[`MSEL_ST_SERVICE] = hw_fail_s | (st_q.hv == MSEL_HV_DEAD); // RULE18
		live[`MSEL_ST_HV_ON] = hv_live; // RULE14
		live[`MSEL_ST_FINE_ADJ] = fine_adjust_en; // RULE22
		live = live & `MSEL_ST_VALID; // RULE23 RULE24
	end

	// Event conditions: the "not good" side of each watched status flag
	always_comb begin
		ev_set = '0;
		ev_set[`MSEL_EV_TEMP] = temp_bad_s; // RULE1 RULE8
		ev_set[`MSEL_EV_SUPPLY] = supply_bad_s; // RULE8
		ev_set[`MSEL_EV_LOOP] = loop_open_s; // RULE8
		ev_set[`MSEL_EV_INPUT] = st_q.in_err; // RULE9
		ev_set[`MSEL_EV_SERVICE] = live[`MSEL_ST_SERVICE]; // RULE9
	end

	// Host clears: write-one per bit, or everything on the global clear
	always_comb begin
		ev_clr = '0;
		if (cmd_valid && cmd_op == MSEL_OP_EVENT_W1C) begin
			ev_clr = cmd_data; // RULE2
		end else if (cmd_valid && cmd_op == MSEL_OP_CLEAR_ALL) begin
			ev_clr = '1; // RULE3
		end
	end

	// Combinational so that release is immediate when event or mask drops
	assign blocking = |(st_q.evt & event_mask & `MSEL_EV_BLOCKING); // RULE7 RULE10

	// Next-state of the whole core
	always_comb begin
		st_d = st_q;
		st_d.sts = live;
		// Set wins over a clear in the same cycle so no event is lost
		st_d.evt = ((st_q.evt & ~ev_clr) | ev_set) & `MSEL_EV_VALID; // RULE1 RULE2 RULE24
		st_d.rsp_valid = 1'b0;
		st_d.rsp_refused = 1'b0;
		st_d.clr_ch = 1'b0;
		st_d.set_grant = 1'b0;
		st_d.on_grant = 1'b0;
		st_d.ramp_off = temp_bad_s; // RULE16
		st_d.emcy_off = loop_open_s; // RULE17
		st_d.fast_down = pwr_fail_s; // RULE20
		if (cmd_valid) begin
			st_d.rsp_valid = 1'b1;
			st_d.rsp_data = '0;
			case (cmd_op)
				MSEL_OP_READ_STATUS: begin
					st_d.rsp_data = st_q.sts;
				end
				MSEL_OP_READ_EVENT: begin
					st_d.rsp_data = st_q.evt;
				end
				MSEL_OP_CLEAR_ALL: begin
					st_d.clr_ch = 1'b1; // RULE3
				end
				MSEL_OP_CLEAR_CH: begin
					st_d.clr_ch = 1'b1; // RULE4
				end
				MSEL_OP_SET_VALUE: begin
					if (!cmd_range_ok) begin
						st_d.in_err = 1'b1; // RULE15
						st_d.rsp_refused = 1'b1;
					end else if (cmd_raise && blocking
						&& (hv_live || st_q.hv == MSEL_HV_ON)) begin
						st_d.rsp_refused = 1'b1; // RULE5
					end else begin
						st_d.in_err = 1'b0; // RULE15
						st_d.set_grant = 1'b1;
					end
				end
				MSEL_OP_HV_ON: begin
					if (st_q.hv == MSEL_HV_DEAD || hw_fail_s) begin
						st_d.rsp_refused = 1'b1; // RULE18
					end else if (st_q.hv == MSEL_HV_OFF && blocking) begin
						st_d.rsp_refused = 1'b1; // RULE6
					end else begin
						st_d.hv = MSEL_HV_ON;
						st_d.on_grant = 1'b1;
					end
				end
				MSEL_OP_HV_OFF: begin
					if (st_q.hv != MSEL_HV_DEAD) begin
						st_d.hv = MSEL_HV_OFF;
					end
				end
				default: begin
					st_d.rsp_data = '0;
				end
			endcase
		end
		// Safety shutdowns override the high-voltage state and switch-on grant the host asked for this cycle
		if (hw_fail_s || st_q.hv == MSEL_HV_DEAD) begin
			st_d.hv = MSEL_HV_DEAD; // RULE18
			st_d.on_grant = 1'b0;
		end else if (loop_open_s || temp_bad_s) begin
			st_d.hv = MSEL_HV_OFF; // RULE16 RULE17
			st_d.on_grant = 1'b0;
		end
		// Enable kept as its own flop so the output carries no decode glitch
		st_d.hv_en = (st_d.hv == MSEL_HV_ON); // RULE18
	end

	// Single state register; the dead state only leaves through reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output is a field of the state register
	assign rsp_valid = st_q.rsp_valid;
	assign rsp_data = st_q.rsp_data;
	assign rsp_refused = st_q.rsp_refused;
	assign module_live_status = st_q.sts;
	assign module_event_latch = st_q.evt;
	assign clear_channel_events_cmd = st_q.clr_ch;
	assign set_value_grant = st_q.set_grant;
	assign hv_on_grant = st_q.on_grant;
	assign hv_enable = st_q.hv_en;
	assign ramp_down_all = st_q.ramp_off;
	assign emergency_off_all = st_q.emcy_off;
	assign power_fail_discharge = st_q.fast_down;
	assign hardware_fault_flag = st_q.sts[`MSEL_ST_SERVICE];
	assign module_healthy = st_q.sts[`MSEL_ST_MOD_OK];
	assign all_channels_healthy = st_q.sts[`MSEL_ST_NO_SUM_ERR];

	// Checks on event capture, clearing, blocking, status flags and safety shutdowns
	a_event_capture: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE1
		temp_bad_s |=> st_q.evt[`MSEL_EV_TEMP])
		else $error("temperature event not captured");

	a_event_sticky: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE2
		st_q.evt[`MSEL_EV_LOOP] && !(cmd_valid && (cmd_op == MSEL_OP_CLEAR_ALL
		|| (cmd_op == MSEL_OP_EVENT_W1C && cmd_data[`MSEL_EV_LOOP])))
		|=> st_q.evt[`MSEL_EV_LOOP])
		else $error("loop event dropped without clear");

	a_clear_all: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE3
		cmd_valid && cmd_op == MSEL_OP_CLEAR_ALL && ev_set == 32'h00000000
		|=> st_q.evt == 32'h00000000 && clear_channel_events_cmd)
		else $error("global clear incomplete");

	a_clear_chan: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE4
		cmd_valid && cmd_op == MSEL_OP_CLEAR_CH |=> clear_channel_events_cmd && rsp_valid)
		else $error("channel clear not issued");

	a_raise_block: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE5
		cmd_valid && cmd_op == MSEL_OP_SET_VALUE && cmd_raise && blocking && hv_live
		|=> rsp_refused && !set_value_grant)
		else $error("raise accepted while blocked");

	a_on_block: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE6
		cmd_valid && cmd_op == MSEL_OP_HV_ON && blocking && !hv_enable
		|=> !hv_on_grant && !hv_enable && rsp_refused)
		else $error("switch-on accepted while blocked");

	a_input_free: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE10
		(st_q.evt & ~(32'h1 << `MSEL_EV_INPUT)) == 32'h00000000 |-> !blocking)
		else $error("input error event blocks");

	a_module_good: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE11
		st_q.evt[`MSEL_EV_LOOP] |=> !module_healthy)
		else $error("module good despite loop event");

	a_input_error: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE15
		cmd_valid && cmd_op == MSEL_OP_SET_VALUE && !cmd_range_ok
		|=> rsp_refused ##1 st_q.sts[`MSEL_ST_INPUT_ERR])
		else $error("input error not flagged");

	a_loop_off: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE17
		loop_open_s |=> emergency_off_all && !hv_enable)
		else $error("loop open without shutdown");

	a_service_lock: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE18
		hw_fail_s |=> (!hv_enable && hardware_fault_flag) [*4])
		else $error("hardware failure did not lock");

endmodule

// *** dv/module_status_event_logic_tb_top.sv ***
// Self-checking testbench for the module status and event logic
`timescale 1ns/10ps
module module_status_event_logic_tb_top
	import msel_pkg::*;
;
	// Live status with all pins healthy, all channels stable and fault free
	localparam logic [31:0] ST = 32'h00007700;
	logic ref_clk, rstn, temp_good, supply_good, safety_loop_closed, hw_fail, power_fail;
	logic [31:0] ch_volt_limit, ch_curr_limit, ch_curr_trip, ch_ext_inhibit, ch_volt_bounds;
	logic [31:0] ch_curr_bounds, ch_arc_error, ch_event_summary, ch_event_chmask;
	logic [31:0] ch_hv_active, ch_above_thresh, ch_stable, ch_ramping, event_mask;
	logic fine_adjust_en, kill_en, delayed_trip_act, ramp_limit_dis;
	logic cmd_valid, cmd_range_ok, cmd_raise;
	msel_op_t cmd_op;
	logic [31:0] cmd_data, rsp_data, module_live_status, module_event_latch, r_data, lv;
	logic rsp_valid, rsp_refused, clear_channel_events_cmd, set_value_grant, hv_on_grant;
	logic hv_enable, ramp_down_all, emergency_off_all, power_fail_discharge;
	logic hardware_fault_flag, module_healthy, all_channels_healthy;
	int num_errors = 0;
	int comparisons = 0;

	msel_core DUT (
		.ref_clk, .rstn, .temp_good, .supply_good, .safety_loop_closed, .hw_fail, .power_fail,
		.ch_volt_limit, .ch_curr_limit, .ch_curr_trip, .ch_ext_inhibit, .ch_volt_bounds,
		.ch_curr_bounds, .ch_arc_error, .ch_event_summary, .ch_event_chmask, .ch_hv_active,
		.ch_above_thresh, .ch_stable, .ch_ramping, .event_mask, .fine_adjust_en, .kill_en,
		.delayed_trip_act, .ramp_limit_dis, .cmd_valid, .cmd_op, .cmd_data, .cmd_range_ok,
		.cmd_raise, .rsp_valid, .rsp_data, .rsp_refused, .module_live_status,
		.module_event_latch, .clear_channel_events_cmd, .set_value_grant, .hv_on_grant,
		.hv_enable, .ramp_down_all, .emergency_off_all, .power_fail_discharge,
		.hardware_fault_flag, .module_healthy, .all_channels_healthy
	);

	// Level outputs gathered so one compare covers them all
	assign lv = {25'h0, hv_enable, ramp_down_all, emergency_off_all, power_fail_discharge,
		hardware_fault_flag, module_healthy, all_channels_healthy};

	// 50 MHz reference clock
	always #10 ref_clk = ~ref_clk;

	task automatic summarize();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Healthy module, no faults, no requests pending
	task automatic base();
		{temp_good, supply_good, safety_loop_closed, hw_fail, power_fail} = 5'b11100;
		{ch_volt_limit, ch_curr_limit, ch_curr_trip, ch_ext_inhibit} = 128'h0;
		{ch_volt_bounds, ch_curr_bounds, ch_arc_error, ch_event_summary} = 128'h0;
		{ch_event_chmask, ch_hv_active, ch_above_thresh, ch_ramping} = 128'h0;
		ch_stable = 32'hffffffff;
		event_mask = 32'h0;
		{fine_adjust_en, kill_en, delayed_trip_act, ramp_limit_dis} = 4'b0000;
	endtask

	// Pins need two sync stages plus the state edge, so five edges is ample
	task automatic settle();
		repeat (5) @(posedge ref_clk);
		#1;
	endtask

	task automatic look(input logic [31:0] st);
		settle();
		chk("live status", module_live_status, st);
	endtask

	// One command, answer checked in the single cycle it stands
	task automatic cmd(input msel_op_t op, input logic [31:0] d, input logic ok, input logic up,
		input logic [31:0] fl);
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_range_ok = ok;
		cmd_raise = up;
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b0;
		r_data = rsp_data;
		chk("response flags", {27'h0, rsp_valid, rsp_refused, set_value_grant, hv_on_grant,
			clear_channel_events_cmd}, fl);
	endtask

	task automatic ev(input logic [31:0] e);
		cmd(MSEL_OP_READ_EVENT, 32'h0, 1'b1, 1'b0, 32'h10);
		chk("read event", r_data, e);
		chk("event latch", module_event_latch, e);
	endtask

	task automatic set_flt(input int k);
		case (k)
			0: ch_volt_limit = 32'h8;
			1: ch_curr_limit = 32'h10;
			2: ch_curr_trip = 32'h20;
			3: ch_ext_inhibit = 32'h40;
			4: ch_volt_bounds = 32'h80;
			5: ch_curr_bounds = 32'h100;
			default: ch_arc_error = 32'h80000000;
		endcase
	endtask

	task automatic s_idle();
		look(ST);
		chk("levels", lv, 32'h3);
		ev(32'h0);
		cmd(MSEL_OP_READ_STATUS, 32'h0, 1'b1, 1'b0, 32'h10);
		chk("read status", r_data, ST);
	endtask

	task automatic s_live();
		fine_adjust_en = 1'b1;
		look(ST | 32'h1);
		base();
		kill_en = 1'b1;
		look(ST | 32'h208000);
		ramp_limit_dis = 1'b1;
		look(ST | 32'h8000);
		base();
		delayed_trip_act = 1'b1;
		look(ST | 32'h200000);
		base();
		ch_ramping = 32'h4;
		look(ST & ~32'h200);
		base();
		ch_stable = 32'hfffffffe;
		look(ST & ~32'h200);
		base();
		ch_event_summary = 32'h10;
		look(ST);
		ch_event_chmask = 32'h10;
		look(ST | 32'h800);
		base();
		ch_hv_active = 32'h1;
		look(ST | 32'h8);
		base();
		ch_above_thresh = 32'h80000000;
		look(ST | 32'h8);
		base();
		power_fail = 1'b1;
		look(ST | 32'h10000);
		chk("levels", lv, 32'hb);
		for (int k = 0; k < 7; k++) begin
			base();
			set_flt(k);
			look(ST & ~32'h1100);
			chk("levels", lv, 32'h0);
		end
		base();
		look(ST);
	endtask

	task automatic s_loop();
		safety_loop_closed = 1'b0;
		look(ST & ~32'h1400);
		chk("levels", lv, 32'h11);
		ev(32'h400);
		safety_loop_closed = 1'b1;
		look(ST & ~32'h1000);
		cmd(MSEL_OP_CLEAR_CH, 32'h0, 1'b1, 1'b0, 32'h11);
		ev(32'h400);
		cmd(MSEL_OP_EVENT_W1C, 32'hfffffbff, 1'b1, 1'b0, 32'h10);
		ev(32'h400);
		cmd(MSEL_OP_EVENT_W1C, 32'h400, 1'b1, 1'b0, 32'h10);
		ev(32'h0);
		look(ST);
	endtask

	task automatic s_temp();
		temp_good = 1'b0;
		look(ST & ~32'h5000);
		chk("ramp down", lv & 32'h20, 32'h20);
		temp_good = 1'b1;
		supply_good = 1'b0;
		look(ST & ~32'h3000);
		supply_good = 1'b1;
		ev(32'h6000);
		cmd(MSEL_OP_CLEAR_ALL, 32'h0, 1'b1, 1'b0, 32'h11);
		ev(32'h0);
	endtask

	task automatic s_block();
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h12);
		chk("hv enable", lv & 32'h40, 32'h40);
		supply_good = 1'b0;
		settle();
		supply_good = 1'b1;
		ch_hv_active = 32'h1;
		event_mask = 32'h2000;
		settle();
		cmd(MSEL_OP_SET_VALUE, 32'h0, 1'b1, 1'b1, 32'h18);
		cmd(MSEL_OP_SET_VALUE, 32'h0, 1'b1, 1'b0, 32'h14);
		cmd(MSEL_OP_HV_OFF, 32'h0, 1'b1, 1'b0, 32'h10);
		ch_hv_active = 32'h0;
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h18);
		event_mask = 32'h0;
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h12);
		cmd(MSEL_OP_HV_OFF, 32'h0, 1'b1, 1'b0, 32'h10);
		event_mask = 32'h2000;
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h18);
		cmd(MSEL_OP_EVENT_W1C, 32'h2000, 1'b1, 1'b0, 32'h10);
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h12);
		cmd(MSEL_OP_HV_OFF, 32'h0, 1'b1, 1'b0, 32'h10);
		// Input error is masked but never blocks
		event_mask = 32'h40;
		cmd(MSEL_OP_SET_VALUE, 32'h0, 1'b0, 1'b0, 32'h18);
		settle();
		chk("input error", module_live_status & 32'h40, 32'h40);
		ev(32'h40);
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h12);
		cmd(MSEL_OP_SET_VALUE, 32'h0, 1'b1, 1'b1, 32'h14);
		settle();
		chk("input error", module_live_status & 32'h40, 32'h0);
	endtask

	task automatic s_service();
		hw_fail = 1'b1;
		settle();
		chk("fault levels", lv & 32'h44, 32'h04);
		ev(32'h50);
		hw_fail = 1'b0;
		settle();
		event_mask = 32'h0;
		cmd(MSEL_OP_HV_ON, 32'h0, 1'b1, 1'b0, 32'h18);
		chk("fault levels", lv & 32'h44, 32'h04);
	endtask

	// Main sequence: reset, then each scenario in turn
	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		base();
		cmd_valid = 1'b0;
		cmd_op = MSEL_OP_NOP;
		cmd_data = 32'h0;
		cmd_range_ok = 1'b1;
		cmd_raise = 1'b0;
		repeat (20) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		s_idle();
		s_live();
		s_loop();
		s_temp();
		s_block();
		s_service();
		summarize();
	end

	// Cuts a hang short; the whole run needs far fewer edges
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		summarize();
	end
endmodule
